/* mp_phy_pins.sv */
// PHY digital pin logic: MII clocks and data, management port, straps, reset, LEDs
`timescale 1ns/1ps
`include "mp_regs.svh"

module mp_phy_pins
  import mp_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // MII toward the MAC
  output logic             tx_clk,
  input  wire mp_tx_t      mii_tx,
  output logic             rx_clk,
  output mp_rx_t           mii_rx,
  output logic             crs,
  output logic             col,
  // Management port
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic        mgmt_port_disable,
  output logic             status_change_irq_n_out,
  output logic             status_change_irq_n_oe,
  // Straps and control pins
  input  wire logic        reset_pin_n,
  input  wire logic        signal_detect_media_select,
  input  wire logic        pause_pin,
  input  wire logic        sleep_pin,
  input  wire logic        power_down_pin,
  input  wire logic [4:0]  phy_address_strap,
  input  wire logic [2:0]  led_config_pin_in,
  output logic      [2:0]  led_config_pin_out,
  output logic      [2:0]  led_config_pin_oe,
  // Line side coding logic
  input  wire mp_line_rx_t line_rx,
  output mp_tx_t           line_tx,
  output logic             sleep_mode,
  output logic             power_down_mode,
  // Local register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  mp_pins_t    pin_raw;
  mp_pins_t    pin_s1;
  mp_pins_t    pins;

  always_comb
  begin
    pin_raw = '{rst_n: reset_pin_n, mdc: mdc, mdio: mdio_in, mdis: mgmt_port_disable,
                sdms: signal_detect_media_select, pause: pause_pin, sleep: sleep_pin,
                pdown: power_down_pin, addr: phy_address_strap, cfg: led_config_pin_in,
                tx: mii_tx};
  end

  // Two flops on every outside input
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pin_s1 <= '{rst_n: 1'b1, default: '0};
      pins   <= '{rst_n: 1'b1, default: '0};
    end
    else
    begin
      pin_s1 <= pin_raw;
      pins   <= pin_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset extension and strap capture
  logic [11:0] ext_cnt;
  logic [11:0] next_ext_cnt;
  logic        in_reset;
  logic [4:0]  phy_addr;
  logic [4:0]  next_phy_addr;
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;

  assign in_reset = (ext_cnt != 12'h000);

  // Pin or soft reset reloads the extension count
  always_comb
  begin
    if (!pins.rst_n || ctrl[`MP_CTRL_RESET])
      next_ext_cnt = 12'(`MP_RST_EXT_CYC);
    else if (in_reset)
      next_ext_cnt = ext_cnt - 12'h001;
    else
      next_ext_cnt = ext_cnt;
    next_phy_addr = in_reset ? pins.addr : phy_addr;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ext_cnt  <= 12'(`MP_RST_EXT_CYC);
      phy_addr <= 5'h00;
    end
    else
    begin
      ext_cnt  <= next_ext_cnt;
      phy_addr <= next_phy_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic fiber_mode;
  logic speed_100;
  logic full_duplex;
  logic link_up;
  logic sleeping;
  logic [15:0] cfg;
  logic [15:0] next_cfg;

  assign fiber_mode  = cfg[`MP_CFG_FIBER];
  assign speed_100   = ctrl[`MP_CTRL_SPEED];
  assign full_duplex = ctrl[`MP_CTRL_DUPLEX];
  assign link_up     = fiber_mode ? pins.sdms : line_rx.link;
  assign sleeping    = pins.mdis ? pins.sleep : cfg[`MP_CFG_SLEEP];

  ////////////////////////////////////////////////////////////////////////////
  // MII clock divider
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic       mii_clk;
  logic       next_mii_clk;
  logic       clk_rise;
  logic       clk_fall;
  logic       quiet;

  assign quiet = sleeping || pins.pdown;

  // Half period of 2 cycles at 10 Mb/s, 1 cycle at 100 Mb/s
  always_comb
  begin
    next_div_cnt = div_cnt;
    next_mii_clk = mii_clk;
    clk_rise     = 1'b0;
    clk_fall     = 1'b0;
    if (in_reset)
    begin
      next_div_cnt = 2'h0;
      next_mii_clk = 1'b1;
    end
    else if (quiet)
    begin
      next_div_cnt = 2'h0;
      next_mii_clk = 1'b0;
    end
    else if (div_cnt >= (speed_100 ? 2'(`MP_HALF_100M) : 2'(`MP_HALF_10M)) - 2'h1)
    begin
      next_div_cnt = 2'h0;
      next_mii_clk = !mii_clk;
      clk_rise     = !mii_clk;
      clk_fall     = mii_clk;
    end
    else
      next_div_cnt = div_cnt + 2'h1;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      div_cnt <= 2'h0;
      mii_clk <= 1'b1;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      mii_clk <= next_mii_clk;
    end
  end

  assign tx_clk = mii_clk;
  assign rx_clk = mii_clk;

  ////////////////////////////////////////////////////////////////////////////
  // MII data paths, carrier and collision
  mp_tx_t next_line_tx;
  mp_rx_t next_mii_rx;
  logic   next_crs;
  logic   next_col;
  logic   carrier;

  // Full duplex counts only receive activity
  assign carrier = line_rx.carrier || (!full_duplex && pins.tx.en);

  always_comb
  begin
    next_line_tx = line_tx;
    next_mii_rx  = mii_rx;
    next_crs     = crs;
    if (in_reset || quiet)
    begin
      next_line_tx = '0;
      next_mii_rx  = '0;
      next_crs     = 1'b0;
    end
    else
    begin
      if (clk_rise)
        next_line_tx = pins.tx;
      if (clk_fall)
        next_mii_rx = '{data: line_rx.data, valid: line_rx.valid,
                        error: line_rx.error};
      if (carrier)
        next_crs = 1'b1;
      else if (clk_fall)
        next_crs = 1'b0;
    end
    next_col = !in_reset && !quiet && !full_duplex && line_rx.collision;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      line_tx <= '0;
      mii_rx  <= '0;
      crs     <= 1'b0;
      col     <= 1'b0;
    end
    else
    begin
      line_tx <= next_line_tx;
      mii_rx  <= next_mii_rx;
      crs     <= next_crs;
      col     <= next_col;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management frames and register file
  mp_mdio_st_t mst;
  mp_mdio_st_t next_mst;
  logic        mdc_d;
  logic        mdc_rise;
  logic        mdc_fall;
  logic [5:0]  pre_cnt;
  logic [5:0]  next_pre_cnt;
  logic [12:0] hdr;
  logic [12:0] next_hdr;
  logic [4:0]  bit_cnt;
  logic [4:0]  next_bit_cnt;
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic        is_read;
  logic        next_is_read;
  logic [4:0]  reg_sel;
  logic [4:0]  next_reg_sel;
  logic        next_mdio_out;
  logic        next_mdio_oe;
  logic [13:0] frame;
  logic        md_wr;
  logic        md_rd_sc;
  logic [15:0] adv;
  logic [15:0] next_adv;
  logic [15:0] ie;
  logic [15:0] next_ie;
  logic [15:0] sc;
  logic [15:0] next_sc;
  logic [15:0] ledc;
  logic [15:0] next_ledc;
  logic [15:0] next_reg_rdata;
  logic [2:0]  prev_state;
  logic [2:0]  next_prev_state;

  assign mdc_rise = pins.mdc && !mdc_d;
  assign mdc_fall = !pins.mdc && mdc_d;
  assign frame    = {hdr, pins.mdio};

  // Read view of the register file
  function automatic logic [15:0] reg_value(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      `MP_REG_CTRL:  v = ctrl;
      `MP_REG_STAT:  v = `MP_STAT_RESET | (16'(link_up) << `MP_STAT_LINK);
      `MP_REG_ADV:   v = adv;
      `MP_REG_CFG:   v = cfg;
      `MP_REG_STAT2: v = (16'(speed_100) << `MP_STAT2_SPEED)
                       | (16'(link_up) << `MP_STAT2_LINK)
                       | (16'(full_duplex) << `MP_STAT2_DUPLEX);
      `MP_REG_IE:    v = ie;
      `MP_REG_SC:    v = sc;
      `MP_REG_LED:   v = ledc;
      default:       v = 16'h0000;
    endcase
    return v;
  endfunction

  // Frame decoder: preamble, 14 header bits, turnaround, 16 data bits
  always_comb
  begin
    next_mst      = mst;
    next_pre_cnt  = pre_cnt;
    next_hdr      = hdr;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_is_read  = is_read;
    next_reg_sel  = reg_sel;
    next_mdio_out = mdio_out;
    next_mdio_oe  = mdio_oe;
    md_wr         = 1'b0;
    md_rd_sc      = 1'b0;
    if (in_reset || pins.mdis)
    begin
      next_mst     = MP_IDLE;
      next_pre_cnt = 6'h00;
      next_mdio_oe = 1'b0;
      next_mdio_out = 1'b0;
    end
    else if (mdc_rise)
    begin
      unique case (mst)
        MP_IDLE:
        begin
          if (pins.mdio)
            next_pre_cnt = (pre_cnt == 6'(`MP_PREAMBLE)) ? pre_cnt : pre_cnt + 6'h01;
          else if (pre_cnt == 6'(`MP_PREAMBLE))
          begin
            next_mst     = MP_HDR;
            next_hdr     = 13'h0000;
            next_bit_cnt = 5'h01;
          end
          else
            next_pre_cnt = 6'h00;
        end
        MP_HDR:
        begin
          next_hdr     = frame[12:0];
          next_bit_cnt = bit_cnt + 5'h01;
          next_pre_cnt = 6'h00;
          if (bit_cnt == 5'h0d)
          begin
            next_reg_sel = frame[4:0];
            next_bit_cnt = 5'h00;
            next_is_read = (frame[11:10] == `MP_OP_RD);
            next_shreg   = reg_value(frame[4:0]);
            // Only a well-formed frame for our address proceeds
            if (frame[13:12] == `MP_ST && frame[9:5] == phy_addr
                && (frame[11:10] == `MP_OP_RD || frame[11:10] == `MP_OP_WR))
            begin
              next_mst = MP_XFER;
              md_rd_sc = (frame[11:10] == `MP_OP_RD) && (frame[4:0] == `MP_REG_SC);
            end
            else
              next_mst = MP_IDLE;
          end
        end
        MP_XFER:
        begin
          next_bit_cnt = bit_cnt + 5'h01;
          if (!is_read && bit_cnt >= 5'h02)
            next_shreg = {shreg[14:0], pins.mdio};
          if (bit_cnt == 5'h11)
          begin
            next_mst = MP_IDLE;
            md_wr    = !is_read;
          end
        end
      endcase
    end
    else if (mdc_fall)
    begin
      if (mst == MP_XFER && is_read && bit_cnt == 5'h01)
      begin
        next_mdio_oe  = 1'b1;
        next_mdio_out = 1'b0;
      end
      else if (mst == MP_XFER && is_read && bit_cnt >= 5'h02)
      begin
        next_mdio_oe  = 1'b1;
        next_mdio_out = shreg[15];
        next_shreg    = {shreg[14:0], 1'b0};
      end
      else
        next_mdio_oe = 1'b0;
    end
  end

  // Register updates: reset loads strap defaults, then both ports may write
  always_comb
  begin
    next_ctrl = ctrl;
    next_adv  = adv;
    next_cfg  = cfg;
    next_ie   = ie;
    next_sc   = sc;
    next_ledc = ledc;
    next_prev_state = {link_up, speed_100, full_duplex};
    next_reg_rdata  = reg_read ? reg_value(reg_addr) : 16'h0000;
    if (in_reset)
    begin
      next_ctrl = (16'(pins.cfg[1]) << `MP_CTRL_SPEED)
                | (16'(pins.cfg[0]) << `MP_CTRL_AUTONEG)
                | (16'(pins.cfg[2]) << `MP_CTRL_DUPLEX);
      next_adv  = `MP_ADV_RESET | (16'(pins.pause) << `MP_ADV_PAUSE);
      next_cfg  = 16'(pins.sdms) << `MP_CFG_FIBER;
      next_ie   = 16'h0000;
      next_sc   = 16'h0000;
      next_ledc = `MP_LED_RESET;
    end
    else
    begin
      if (reg_write)
      begin
        unique case (reg_addr)
          `MP_REG_CTRL: next_ctrl = reg_wdata;
          `MP_REG_ADV:  next_adv  = reg_wdata;
          `MP_REG_CFG:  next_cfg  = reg_wdata;
          `MP_REG_IE:   next_ie   = reg_wdata;
          `MP_REG_LED:  next_ledc = reg_wdata;
          default:      next_ctrl = ctrl;
        endcase
      end
      if (md_wr)
      begin
        unique case (reg_sel)
          `MP_REG_CTRL: next_ctrl = {shreg[14:0], pins.mdio};
          `MP_REG_ADV:  next_adv  = {shreg[14:0], pins.mdio};
          `MP_REG_CFG:  next_cfg  = {shreg[14:0], pins.mdio};
          `MP_REG_IE:   next_ie   = {shreg[14:0], pins.mdio};
          `MP_REG_LED:  next_ledc = {shreg[14:0], pins.mdio};
          default:      next_ctrl = ctrl;
        endcase
      end
      // Read clears, a change in the same cycle still sets
      if (md_rd_sc || (reg_read && reg_addr == `MP_REG_SC))
        next_sc = 16'h0000;
      next_sc[`MP_SC_LINK]   = next_sc[`MP_SC_LINK]   | (prev_state[2] != link_up);
      next_sc[`MP_SC_SPEED]  = next_sc[`MP_SC_SPEED]  | (prev_state[1] != speed_100);
      next_sc[`MP_SC_DUPLEX] = next_sc[`MP_SC_DUPLEX] | (prev_state[0] != full_duplex);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      mst        <= MP_IDLE;
      mdc_d      <= 1'b0;
      pre_cnt    <= 6'h00;
      hdr        <= 13'h0000;
      bit_cnt    <= 5'h00;
      shreg      <= 16'h0000;
      is_read    <= 1'b0;
      reg_sel    <= 5'h00;
      mdio_out   <= 1'b0;
      mdio_oe    <= 1'b0;
      ctrl       <= 16'h0000;
      adv        <= `MP_ADV_RESET;
      cfg        <= 16'h0000;
      ie         <= 16'h0000;
      sc         <= 16'h0000;
      ledc       <= `MP_LED_RESET;
      prev_state <= 3'h0;
      reg_rdata  <= 16'h0000;
    end
    else
    begin
      mst        <= next_mst;
      mdc_d      <= pins.mdc;
      pre_cnt    <= next_pre_cnt;
      hdr        <= next_hdr;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      is_read    <= next_is_read;
      reg_sel    <= next_reg_sel;
      mdio_out   <= next_mdio_out;
      mdio_oe    <= next_mdio_oe;
      ctrl       <= next_ctrl;
      adv        <= next_adv;
      cfg        <= next_cfg;
      ie         <= next_ie;
      sc         <= next_sc;
      ledc       <= next_ledc;
      prev_state <= next_prev_state;
      reg_rdata  <= next_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LEDs, interrupt pin and power modes
  logic [2:0] led_sel;

  // Each LED picks its status by a 4-bit code, LED1 in the top nibble
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_led
      logic [3:0] code;
      assign code = ledc[15 - 4 * gi -: 4];
      assign led_sel[gi] = (code == 4'h0) ? speed_100 :
                           (code == 4'h1) ? line_tx.en :
                           (code == 4'h2) ? mii_rx.valid :
                           (code == 4'h3) ? col :
                           (code == 4'h4) ? link_up :
                           (code == 4'h5) ? full_duplex :
                           (code == 4'h7);
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      led_config_pin_out      <= 3'h0;
      led_config_pin_oe       <= 3'h0;
      status_change_irq_n_out <= 1'b0;
      status_change_irq_n_oe  <= 1'b0;
      sleep_mode              <= 1'b0;
      power_down_mode         <= 1'b0;
    end
    else
    begin
      led_config_pin_out      <= in_reset ? 3'h0 : led_sel;
      led_config_pin_oe       <= in_reset ? 3'h0 : 3'h7;
      status_change_irq_n_out <= 1'b0;
      status_change_irq_n_oe  <= !in_reset && ie[`MP_IE_ENABLE] && (sc != 16'h0000);
      sleep_mode              <= !in_reset && sleeping;
      power_down_mode         <= pins.pdown;
    end
  end

endmodule

/* mp_regs.svh */
// Register indices, field positions, reset values and timing counts of the PHY pin block
`ifndef MP_REGS_SVH
`define MP_REGS_SVH
`define MP_REG_CTRL       5'h00
`define MP_REG_STAT       5'h01
`define MP_REG_ADV        5'h04
`define MP_REG_CFG        5'h10
`define MP_REG_STAT2      5'h11
`define MP_REG_IE         5'h12
`define MP_REG_SC         5'h13
`define MP_REG_LED        5'h14
`define MP_CTRL_RESET     15
`define MP_CTRL_SPEED     13
`define MP_CTRL_AUTONEG   12
`define MP_CTRL_DUPLEX    8
`define MP_STAT_RESET     16'h7809
`define MP_STAT_LINK      2
`define MP_ADV_RESET      16'h01e1
`define MP_ADV_PAUSE      10
`define MP_CFG_FIBER      0
`define MP_CFG_SLEEP      6
`define MP_STAT2_SPEED    14
`define MP_STAT2_LINK     10
`define MP_STAT2_DUPLEX   9
`define MP_IE_ENABLE      1
`define MP_SC_LINK        4
`define MP_SC_SPEED       3
`define MP_SC_DUPLEX      2
`define MP_LED_RESET      16'h0420
`define MP_CLK_KHZ        10000
`define MP_RST_EXT_US     258
`define MP_RST_EXT_CYC    ((`MP_RST_EXT_US * `MP_CLK_KHZ) / 1000)
`define MP_CLK_10M_KHZ    2500
`define MP_HALF_10M       (`MP_CLK_KHZ / (2 * `MP_CLK_10M_KHZ))
`define MP_HALF_100M      1
`define MP_PREAMBLE       32
`define MP_ST             2'b01
`define MP_OP_RD          2'b10
`define MP_OP_WR          2'b01
`endif

/* mp_pkg.sv */
// Types shared by the PHY pin block
package mp_pkg;
  typedef struct packed {
    logic [3:0] data;
    logic       valid;
    logic       error;
  } mp_rx_t;
  typedef struct packed {
    logic [3:0] data;
    logic       en;
    logic       er;
  } mp_tx_t;
  typedef struct packed {
    logic [3:0] data;
    logic       valid;
    logic       error;
    logic       carrier;
    logic       collision;
    logic       link;
  } mp_line_rx_t;
  typedef struct packed {
    logic       rst_n;
    logic       mdc;
    logic       mdio;
    logic       mdis;
    logic       sdms;
    logic       pause;
    logic       sleep;
    logic       pdown;
    logic [4:0] addr;
    logic [2:0] cfg;
    mp_tx_t     tx;
  } mp_pins_t;
  typedef enum logic [1:0] {MP_IDLE, MP_HDR, MP_XFER} mp_mdio_st_t;
endpackage

/* mp_phy_pins_assertions.sv */
// Port-level checks on the PHY pin block
`timescale 1ns/1ps
module mp_phy_pins_assertions
  import mp_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // Watched ports
  input wire logic        tx_clk,
  input wire logic        rx_clk,
  input wire mp_rx_t      mii_rx,
  input wire logic        crs,
  input wire logic        col,
  input wire logic        mdc,
  input wire logic        mdio_oe,
  input wire logic        mgmt_port_disable,
  input wire logic        status_change_irq_n_out,
  input wire logic        status_change_irq_n_oe,
  input wire mp_line_rx_t line_rx,
  input wire logic        sleep_mode,
  input wire logic        power_down_mode,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_read
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Clocks and receive path
  a_tx_clk_rate: assert property (disable iff (reset || sleep_mode || power_down_mode)
    $fell(tx_clk) |=> ##[0:1] $rose(tx_clk)) else $error("tx clock low too long");
  a_rx_capture: assert property (
    $fell(rx_clk) |-> mii_rx == {$past(line_rx.data), $past(line_rx.valid), $past(line_rx.error)})
    else $error("receive nibble not taken at rx clock fall");
  a_crs_rise: assert property (line_rx.carrier && !crs |=> crs)
    else $error("carrier sense late");
  a_crs_fall: assert property ($fell(crs) |-> $fell(rx_clk))
    else $error("carrier sense dropped off the rx clock");
  a_col_cause: assert property (col |-> $past(line_rx.collision))
    else $error("collision without cause");
  // Interrupt and management port
  a_irq_clear: assert property (
    reg_read && reg_addr == 5'h13 && $stable(line_rx.link) |-> ##[1:2] !status_change_irq_n_oe)
    else $error("status read left interrupt pulled");
  a_irq_drive: assert property (status_change_irq_n_oe |-> !status_change_irq_n_out)
    else $error("interrupt pin driven high");
  a_mdis_silent: assert property ($rose(mdio_oe) |-> !mgmt_port_disable)
    else $error("management drive while disabled");
  a_mdio_on_fall: assert property ($changed(mdio_oe) |-> !mdc)
    else $error("management drive changed with clock high");
  c_mgmt_read: cover property ($rose(mdio_oe));
  c_irq: cover property ($rose(status_change_irq_n_oe));
  c_col: cover property ($rose(col));
endmodule

/* mp_sta_model.sv */
// Management station and MAC transmit model facing the PHY pin block
`timescale 1ns/1ps
`include "mp_regs.svh"
module mp_sta_model
  import mp_pkg::*;
(
  // Clock
  input  wire logic   clock,
  // MII transmit side
  input  wire logic   tx_clk,
  input  wire logic   tx_on,
  output mp_tx_t      mii_tx,
  // Management port
  input  wire logic   mdio_out,
  input  wire logic   mdio_oe,
  output logic        mdc,
  output logic        mdio_in,
  output logic [15:0] rd_data,
  output logic        rd_done
);
  logic sta_oe = 1'b0;
  logic sta_d = 1'b1;
  logic tx_prev = 1'b1;
  initial
  begin
    mii_tx = '0;
    mdc = 1'b0;
    rd_data = 16'h0000;
    rd_done = 1'b0;
  end
  // Shared data line, pulled up when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (sta_oe ? sta_d : 1'b1);
  // New nibble after each transmit clock rise, enable only with data
  always @(posedge clock)
  begin
    tx_prev <= tx_clk;
    if (tx_clk && !tx_prev)
    begin
      mii_tx.data <= tx_on ? mii_tx.data + 4'h1 : 4'h0;
      mii_tx.en   <= tx_on;
      mii_tx.er   <= 1'b0;
    end
  end
  // One bit: 400 ns low, then 400 ns high, sampled at the rise
  task automatic mbit(input logic drive, input logic b, output logic r);
    @(posedge clock);
    mdc    <= 1'b0;
    sta_oe <= drive;
    sta_d  <= b;
    repeat (4) @(posedge clock);
    mdc <= 1'b1;
    r = mdio_in;
    repeat (3) @(posedge clock);
  endtask
  // Whole frame: preamble, start, op, addresses, turnaround, data, idle
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd);
    logic [45:0] hdr;
    logic        r;
    hdr = {32'hffffffff, `MP_ST, rd ? `MP_OP_RD : `MP_OP_WR, pa, ra};
    for (int i = 45; i >= 0; i--) mbit(1'b1, hdr[i], r);
    mbit(!rd, 1'b1, r);
    mbit(!rd, 1'b0, r);
    for (int i = 15; i >= 0; i--)
    begin
      mbit(!rd, wd[i], r);
      rd_data[i] <= r;
    end
    mbit(1'b0, 1'b1, r);
    rd_done <= rd;
    @(posedge clock);
    rd_done <= 1'b0;
  endtask
endmodule

/* mp_phy_pins_tb.sv */
// Self-checking bench for the PHY pin block
`timescale 1ns/1ps
`include "mp_regs.svh"
module mp_phy_pins_tb
  import mp_pkg::*;
  ;
  // Bench-driven inputs
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        mdis = 1'b0;
  logic        reset_pin_n = 1'b1;
  logic        sdms = 1'b1;
  logic        pause = 1'b1;
  logic        sleep_pin = 1'b0;
  logic        pdown = 1'b0;
  logic        tx_on = 1'b0;
  logic [4:0]  strap = 5'h00;
  logic [2:0]  cfg = 3'b001;
  mp_line_rx_t line_rx = '0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  // Outputs, pins and bench state
  logic        tx_clk, rx_clk, crs, col, mdc, mdio_in, mdio_out, mdio_oe, irq_out, irq_oe;
  logic        sleep_mode, pd_mode, rd_done;
  logic        rd_q1 = 1'b0;
  logic [2:0]  led_out, led_oe, led_pin;
  logic [15:0] reg_rdata, rd_data;
  mp_tx_t      mii_tx, line_tx;
  mp_rx_t      mii_rx;
  logic [31:0] seed = 32'h00000038;
  logic [31:0] exp_q[$];
  int          bad_count = 0;
  int          samples_checked = 0;
  always #50 clock = ~clock;
  // Strap pulls show through when the LED drivers let go
  assign led_pin = (led_oe & led_out) | (~led_oe & cfg);
  mp_phy_pins u_mp_phy_pins (.clock(clock), .reset(reset), .tx_clk(tx_clk), .mii_tx(mii_tx),
    .rx_clk(rx_clk), .mii_rx(mii_rx), .crs(crs), .col(col), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mgmt_port_disable(mdis),
    .status_change_irq_n_out(irq_out), .status_change_irq_n_oe(irq_oe),
    .reset_pin_n(reset_pin_n), .signal_detect_media_select(sdms), .pause_pin(pause),
    .sleep_pin(sleep_pin), .power_down_pin(pdown), .phy_address_strap(strap),
    .led_config_pin_in(led_pin), .led_config_pin_out(led_out), .led_config_pin_oe(led_oe),
    .line_rx(line_rx), .line_tx(line_tx), .sleep_mode(sleep_mode), .power_down_mode(pd_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata));
  mp_sta_model u_mp_sta_model (.clock(clock), .tx_clk(tx_clk), .tx_on(tx_on), .mii_tx(mii_tx),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in), .rd_data(rd_data),
    .rd_done(rd_done));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] v);
    exp_q.push_back({m, v});
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
  endtask
  // Reset stretch: clocks held high, LED drivers on afterwards
  task automatic ext();
    tk(100);
    #1 check(tx_clk, 1'b1);
    tk(2500);
    #1 check(led_oe, 3'b111);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Each read answer meets the oldest expectation
  always @(posedge clock)
  begin
    rd_q1 <= reg_read;
    if (rd_q1 || rd_done)
    begin
      check((rd_q1 ? reg_rdata : rd_data) & exp_q[0][31:16], exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
  end
  // Watchdog well above the run of about 10000 cycles
  initial
  begin
    tk(40000);
    bad_count++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    strap = 5'(xs());
    tk(5);
    reset <= 1'b0;
    ext();
    rd(`MP_REG_ADV, 16'hffff, `MP_ADV_RESET | (16'h1 << `MP_ADV_PAUSE));
    rd(`MP_REG_LED, 16'hffff, `MP_LED_RESET);
    rd(`MP_REG_CFG, 16'h0001, 16'h0001);
    rd(`MP_REG_CTRL, 16'h3100, 16'h1000);
    rd(5'h1f, 16'hffff, 16'h0000);
    wr(`MP_REG_STAT, 16'h0000);
    rd(`MP_REG_STAT, 16'hf800, `MP_STAT_RESET & 16'hf800);
    wr(`MP_REG_IE, 16'h0002);
    sdms <= 1'b0;
    tk(5);
    #1 check(irq_oe, 1'b1);
    rd(`MP_REG_SC, 16'h0010, 16'h0010);
    tk(3);
    #1 check(irq_oe, 1'b0);
    tx_on <= 1'b1;
    tk(12);
    #1 check({crs, line_tx.en}, 2'b11);
    tk(1);
    tx_on <= 1'b0;
    tk(16);
    for (int i = 0; i < 24; i++)
    begin
      line_rx <= {4'(xs()), 1'b1, i == 9, 1'b1, i > 15, 1'b1};
      tk(1);
    end
    #1 check({crs, col}, 2'b11);
    tk(1);
    line_rx <= 9'h001;
    wr(`MP_REG_CTRL, 16'h3100);
    line_rx.collision <= 1'b1;
    tx_on <= 1'b1;
    tk(16);
    #1 check({crs, col}, 2'b00);
    tk(1);
    line_rx.collision <= 1'b0;
    tx_on <= 1'b0;
    exp_q.push_back({16'hffff, `MP_LED_RESET});
    u_mp_sta_model.frame(1'b1, strap, `MP_REG_LED, 16'h0000);
    u_mp_sta_model.frame(1'b0, strap, `MP_REG_IE, 16'h0000);
    rd(`MP_REG_IE, 16'h0002, 16'h0000);
    u_mp_sta_model.frame(1'b0, strap ^ 5'h01, `MP_REG_IE, 16'h0002);
    rd(`MP_REG_IE, 16'h0002, 16'h0000);
    mdis <= 1'b1;
    u_mp_sta_model.frame(1'b0, strap, `MP_REG_IE, 16'h0002);
    rd(`MP_REG_IE, 16'h0002, 16'h0000);
    sleep_pin <= 1'b1;
    tk(8);
    #1 check({sleep_mode, tx_clk}, 2'b10);
    tk(1);
    sleep_pin <= 1'b0;
    mdis <= 1'b0;
    wr(`MP_REG_CFG, 16'h0041);
    tk(8);
    #1 check(sleep_mode, 1'b1);
    wr(`MP_REG_CFG, 16'h0001);
    pdown <= 1'b1;
    tk(8);
    #1 check({sleep_mode, pd_mode}, 2'b01);
    tk(1);
    pdown <= 1'b0;
    pause <= 1'b0;
    sdms <= 1'b0;
    reset_pin_n <= 1'b0;
    tk(3);
    reset_pin_n <= 1'b1;
    ext();
    rd(`MP_REG_CFG, 16'h0001, 16'h0000);
    rd(`MP_REG_ADV, 16'h0400, 16'h0000);
    wr(`MP_REG_CTRL, 16'h9100);
    tk(4);
    #1 check(tx_clk, 1'b1);
    ext();
    rd(`MP_REG_CTRL, 16'h8000, 16'h0000);
    tk(4);
    results();
  end
endmodule
bind mp_phy_pins mp_phy_pins_assertions u_mp_phy_pins_assertions (.clock(clock), .reset(reset),
  .tx_clk(tx_clk), .rx_clk(rx_clk), .mii_rx(mii_rx), .crs(crs), .col(col), .mdc(mdc),
  .mdio_oe(mdio_oe), .mgmt_port_disable(mgmt_port_disable),
  .status_change_irq_n_out(status_change_irq_n_out),
  .status_change_irq_n_oe(status_change_irq_n_oe), .line_rx(line_rx), .sleep_mode(sleep_mode),
  .power_down_mode(power_down_mode), .reg_addr(reg_addr), .reg_read(reg_read));
